// ---- include/eeprom_config_map.svh ----
// Purpose: Offsets, field positions, reset values and counts of the config loader
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef EEPROM_CONFIG_MAP_SVH
`define EEPROM_CONFIG_MAP_SVH

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_DATA       8'h04
`define REG_BASE       8'h08
`define REG_MAC_LO     8'h0C
`define REG_MAC_MID    8'h10
`define REG_MAC_HI     8'h14
`define REG_BOOT       8'h18

// Control register fields
`define CTRL_ADDR_LSB  0
`define CTRL_OP_LSB    8
`define CTRL_BUSY_BIT  16
`define CTRL_BIG_BIT   17
`define CTRL_SIZED_BIT 18
`define CTRL_DONE_BIT  19
`define CTRL_GO_BIT    31

// Boot options word fields
`define BOOT_SLOW_BIT  1
`define BOOT_WIDE_BIT  0
`define BOOT_RESET     16'h0000

// Serial word layout and opcodes
`define OP_READ        2'b10
`define OP_WRITE       2'b01
`define WORD_LAST      3'h6
`define OUT_LAST_SMALL 5'h08
`define OUT_LAST_BIG   5'h0A
`define DATA_BITS      5'h10
`define IN_LAST        5'h0F

// Timing counts
`define PHASE_LAST     4'hF
`define STRAP_WAIT     2'h3

`endif

// ---- include/eeprom_config_pkg.sv ----
// Purpose: Types shared by the config loader
// Assumes: Constants live in eeprom_config_map.svh
// Notes:   State encodings are left to the tool
package eeprom_config_pkg;

   typedef enum logic [1:0] {L_STRAP, L_ISSUE, L_WAIT, L_READY} loader_state_t;
   typedef enum logic [2:0] {K_IDLE, K_SEL, K_OUT, K_IN, K_GAP} link_state_t;

endpackage : eeprom_config_pkg

// ---- hw/eeprom_config_loader.sv ----
// Purpose: Loads boot configuration from a microwire serial EEPROM and gives
//          software a register path to read and write that EEPROM
// Assumes: sys_clk 250 MHz; link_clk free-running, serial clock is link_clk/16
// Notes:   Part size is probed once after reset from the dummy zero bit
// Notes on behaviour
// - Configuration storage is reached over a microwire serial link.
// - The 6-bit or 8-bit address part is detected and addressed to match.
// - Every EEPROM read or write transfer moves one whole 16-bit word; opcode 00 moves no data.
// - With the load-enable pin high, words 0 to 6 are read once after reset.
// - Each word fetched by the load, except words 4 and 5, goes to its host-readable register.
// - Software reads and writes any EEPROM word through the control register.
// - Word 0 is the base address, words 1-3 the MAC bytes, 4-5 reserved.
// - Words 7 and up are never touched by the automatic load.
// - Bit 1 of word 6 picks the internal clock, 1 meaning the slow rate.
// - The fast clock is selected from reset until word 6 asks otherwise.
// - Bit 0 of word 6 picks the host bus width, 1 meaning 16 bits.
`timescale 1ns/1ps
`include "eeprom_config_map.svh"

module eeprom_config_loader import eeprom_config_pkg::*; (
   input  wire logic        sys_clk,                 // Core clock
   input  wire logic        rst_n,                   // Sync reset, active low
   input  wire logic        psel,                    // APB select
   input  wire logic        penable,                 // APB enable
   input  wire logic        pwrite,                  // APB direction
   input  wire logic [7:0]  paddr,                   // APB byte address
   input  wire logic [31:0] pwdata,                  // APB write data
   output logic      [31:0] prdata,                  // APB read data
   output logic             pready,                  // APB ready
   output logic             pslverr,                 // APB error, unmapped address
   input  wire logic        eeprom_load_enable_pin,  // Boot load strap pin
   output logic             clk_slow_select,         // 1 = slow internal clock
   output logic             host_bus_width_select,   // 1 = 16-bit host bus
   output logic             config_loaded,           // Boot words taken from EEPROM
   input  wire logic        link_clk,                // Serial link clock
   input  wire logic        rom_do,                  // EEPROM data out
   output logic             rom_cs,                  // EEPROM chip select
   output logic             rom_sk,                  // EEPROM serial clock
   output logic             rom_di                   // EEPROM data in
);

   // System side state
   loader_state_t lst;
   logic [1:0]    en_sync;
   logic [1:0]    strap_cnt;
   logic [2:0]    wcnt;
   logic [1:0]    cmd_op;
   logic [7:0]    cmd_addr;
   logic [15:0]   cmd_wdata;
   logic          req_tgl;
   logic          busy;
   logic [1:0]    done_sync;
   logic          done_seen;
   logic [15:0]   rd_word;
   logic          big_s;
   logic          sized_s;
   logic [1:0]    sized_sync;
   logic [15:0]   base;
   logic [15:0]   mac_lo;
   logic [15:0]   mac_mid;
   logic [15:0]   mac_hi;
   logic [15:0]   boot;

   // Link side state
   link_state_t   kst;
   logic [1:0]    lrst;
   logic [1:0]    do_sync;
   logic [1:0]    req_sync;
   logic          req_seen;
   logic          done_tgl;
   logic [3:0]    phase;
   logic [4:0]    bitcnt;
   logic [26:0]   sreg;
   logic [1:0]    k_op;
   logic          probe;
   logic          big;
   logic          sized;
   logic [15:0]   rdata;

   // APB decode and read selection
   wire        setup     = psel & ~penable;
   wire        access    = psel & penable & pready;
   wire        hit_ctrl  = (paddr == `REG_CTRL);
   wire        hit_data  = (paddr == `REG_DATA);
   wire        hit_base  = (paddr == `REG_BASE);
   wire        hit_lo    = (paddr == `REG_MAC_LO);
   wire        hit_mid   = (paddr == `REG_MAC_MID);
   wire        hit_hi    = (paddr == `REG_MAC_HI);
   wire        hit_boot  = (paddr == `REG_BOOT);
   wire        mapped    = hit_ctrl | hit_data | hit_base | hit_lo | hit_mid | hit_hi | hit_boot;
   wire [31:0] ctrl_view = {12'h000, loaded_bit(config_loaded), sized_s, big_s, busy,
                            6'h00, cmd_op, cmd_addr};
   wire [15:0] half_mux  = hit_data ? rd_word :
                           hit_base ? base :
                           hit_lo   ? mac_lo :
                           hit_mid  ? mac_mid :
                           hit_hi   ? mac_hi :
                           hit_boot ? boot : 16'h0000;
   wire [31:0] rd_mux    = hit_ctrl ? ctrl_view : {16'h0000, half_mux};

   // Request sources; software is refused while the loader or a transfer runs
   wire        ready_st  = (lst == L_READY);
   wire        sw_go     = access & pwrite & hit_ctrl & pwdata[`CTRL_GO_BIT] & ready_st & ~busy;
   wire        ld_go     = (lst == L_ISSUE);
   wire        issue     = sw_go | ld_go;
   wire        data_wr   = access & pwrite & hit_data & ~busy;
   wire        done_s    = done_sync[1];
   wire        done_evt  = done_s ^ done_seen;
   wire        en_s      = en_sync[1];

   function automatic logic loaded_bit(input logic v);
      loaded_bit = v;
   endfunction : loaded_bit

   // APB answer, zero wait: ready in the access cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Strap pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (!rst_n) en_sync <= 2'b00;
      else        en_sync <= {en_sync[0], eeprom_load_enable_pin};
   end

   // Write data is held steady while a transfer is in flight
   always_ff @(posedge sys_clk) begin
      if (!rst_n)       cmd_wdata <= 16'h0000;
      else if (data_wr) cmd_wdata <= pwdata[15:0];
   end

   // Command launch toward the link and completion pickup
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmd_op    <= `OP_READ;
         cmd_addr  <= 8'h00;
         req_tgl   <= 1'b0;
         busy      <= 1'b0;
         done_sync <= 2'b00;
         done_seen <= 1'b0;
         rd_word   <= 16'h0000;
      end else begin
         done_sync <= {done_sync[0], done_tgl};
         if (issue) begin
            cmd_op   <= sw_go ? pwdata[`CTRL_OP_LSB +: 2] : `OP_READ;
            cmd_addr <= sw_go ? pwdata[`CTRL_ADDR_LSB +: 8] : {5'h00, wcnt};
            req_tgl  <= ~req_tgl;
            busy     <= 1'b1;
         end else if (done_evt) begin
            busy      <= 1'b0;
            done_seen <= done_s;
            rd_word   <= rdata;        // Link holds rdata until the next request
         end
      end
   end

   // Part size status; the probe ends with no done toggle, so size is synchronised
   // on its own. Big settles with sized, so it is taken once sized is seen.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sized_sync <= 2'b00;
         sized_s    <= 1'b0;
         big_s      <= 1'b0;
      end else begin
         sized_sync <= {sized_sync[0], sized};
         sized_s    <= sized_sync[1];
         if (sized_sync[1]) big_s <= big;
      end
   end

   // Boot loader: strap sampled once after release, then words 0..6
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lst           <= L_STRAP;
         strap_cnt     <= 2'h0;
         wcnt          <= 3'h0;
         config_loaded <= 1'b0;
      end else begin
         unique case (lst)
            L_STRAP: begin
               strap_cnt <= strap_cnt + 2'h1;
               if (strap_cnt == `STRAP_WAIT) lst <= en_s ? L_ISSUE : L_READY;
            end
            L_ISSUE: lst <= L_WAIT;
            L_WAIT: begin
               if (done_evt) begin
                  if (wcnt == `WORD_LAST) begin
                     lst           <= L_READY;
                     config_loaded <= 1'b1;
                  end else begin
                     wcnt <= wcnt + 3'h1;
                     lst  <= L_ISSUE;
                  end
               end
            end
            L_READY: lst <= L_READY;
         endcase
      end
   end

   // Loaded words land in host registers; words 4 and 5 are dropped
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         base    <= 16'h0000;
         mac_lo  <= 16'h0000;
         mac_mid <= 16'h0000;
         mac_hi  <= 16'h0000;
         boot    <= `BOOT_RESET;
      end else if (lst == L_WAIT && done_evt) begin
         if (wcnt == 3'h0) base    <= rdata;
         if (wcnt == 3'h1) mac_lo  <= rdata;
         if (wcnt == 3'h2) mac_mid <= rdata;
         if (wcnt == 3'h3) mac_hi  <= rdata;
         if (wcnt == `WORD_LAST) boot <= rdata;
      end
   end

   // Option outputs; fast clock and 8-bit bus until word 6 says otherwise
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         clk_slow_select       <= 1'b0;
         host_bus_width_select <= 1'b0;
      end else begin
         clk_slow_select       <= boot[`BOOT_SLOW_BIT];
         host_bus_width_select <= boot[`BOOT_WIDE_BIT];
      end
   end

   // ---- Link domain ----

   // Reset and input synchronisers on the link clock
   always_ff @(posedge link_clk) begin
      lrst     <= {lrst[0], rst_n};
      do_sync  <= {do_sync[0], rom_do};
      req_sync <= {req_sync[0], req_tgl};
   end

   wire       link_rst_n = lrst[1];
   wire       do_s       = do_sync[1];
   wire       req_pend   = req_sync[1] ^ req_seen;
   wire       bit_end    = (phase == `PHASE_LAST);
   wire [3:0] phase_nx   = phase + 4'h1;
   wire       is_write   = (k_op == `OP_WRITE);
   wire [4:0] out_last   = (big ? `OUT_LAST_BIG : `OUT_LAST_SMALL) +
                           (is_write ? `DATA_BITS : 5'h00);
   wire [26:0] frame_big   = {1'b1, cmd_op, cmd_addr, cmd_wdata};
   wire [26:0] frame_small = {1'b1, cmd_op, cmd_addr[5:0], cmd_wdata, 2'b00};
   wire       small_seen = probe & (bitcnt == `OUT_LAST_SMALL) & ~do_s;

   // Serial engine; one bit takes sixteen link clocks, clock high in the second half
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         kst      <= K_IDLE;
         phase    <= 4'h0;
         bitcnt   <= 5'h00;
         sreg     <= 27'h000_0000;
         k_op     <= `OP_READ;
         probe    <= 1'b0;
         big      <= 1'b1;
         sized    <= 1'b0;
         rdata    <= 16'h0000;
         req_seen <= 1'b0;
         done_tgl <= 1'b0;
         rom_cs   <= 1'b0;
         rom_sk   <= 1'b0;
         rom_di   <= 1'b0;
      end else begin
         unique case (kst)
            K_IDLE: begin
               phase  <= 4'h0;
               bitcnt <= 5'h00;
               if (!sized) begin                   // Size probe: read of word 0
                  k_op  <= `OP_READ;
                  probe <= 1'b1;
                  big   <= 1'b1;
                  sreg  <= {1'b1, `OP_READ, 24'h00_0000};
                  kst   <= K_SEL;
               end else if (req_pend) begin
                  req_seen <= req_sync[1];
                  k_op     <= cmd_op;
                  sreg     <= big ? frame_big : frame_small;
                  kst      <= K_SEL;
               end
            end
            K_SEL: begin
               rom_cs <= 1'b1;
               phase  <= phase_nx;
               rom_di <= sreg[26];
               if (bit_end) kst <= K_OUT;
            end
            K_OUT: begin
               phase  <= phase_nx;
               rom_sk <= phase_nx[3];
               rom_di <= bit_end ? sreg[25] : sreg[26];
               if (bit_end) begin
                  sreg   <= {sreg[25:0], 1'b0};
                  bitcnt <= bitcnt + 5'h01;
                  if (small_seen) begin
                     big    <= 1'b0;
                     sized  <= 1'b1;
                     bitcnt <= 5'h00;
                     kst    <= K_IN;
                  end else if (bitcnt == out_last) begin
                     if (probe) sized <= 1'b1;
                     bitcnt <= 5'h00;
                     kst    <= (k_op == `OP_READ) ? K_IN : K_GAP;
                  end
               end
            end
            K_IN: begin
               phase  <= phase_nx;
               rom_sk <= phase_nx[3];
               rom_di <= 1'b0;
               if (bit_end) begin
                  rdata  <= {rdata[14:0], do_s};
                  bitcnt <= bitcnt + 5'h01;
                  if (bitcnt == `IN_LAST) kst <= K_GAP;
               end
            end
            K_GAP: begin
               rom_cs <= 1'b0;
               rom_sk <= 1'b0;
               rom_di <= 1'b0;
               phase  <= phase_nx;
               if (bit_end) begin
                  kst <= K_IDLE;
                  if (probe) probe    <= 1'b0;
                  else       done_tgl <= ~done_tgl;
               end
            end
            default: kst <= K_IDLE;
         endcase
      end
   end

endmodule : eeprom_config_loader

// ---- tb/eeprom_config_loader_properties.sv ----
// Purpose: Port checks for the config loader
// Assumes: One active-low reset disables both clock domains
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`include "eeprom_config_map.svh"
module eeprom_config_loader_checker (
   input wire logic        sys_clk,                // Core clock
   input wire logic        rst_n,                  // Reset, active low
   input wire logic        psel,                   // APB select
   input wire logic        penable,                // APB enable
   input wire logic [7:0]  paddr,                  // APB address
   input wire logic [31:0] prdata,                 // APB read data
   input wire logic        pready,                 // APB ready
   input wire logic        pslverr,                // APB error
   input wire logic        clk_slow_select,        // Slow clock pick
   input wire logic        host_bus_width_select,  // Host width pick
   input wire logic        config_loaded,          // Boot words taken
   input wire logic        link_clk,               // Link clock
   input wire logic        rom_cs,                 // Chip select
   input wire logic        rom_sk,                 // Serial clock
   input wire logic        rom_di                  // Serial data out
);
   // Register bus timing and decode
   property p_ready_next;
      @(posedge sys_clk) disable iff (!rst_n) psel && !penable |=> pready;
   endproperty
   property p_err_hole;
      @(posedge sys_clk) disable iff (!rst_n)
         pready && paddr > `REG_BOOT |-> pslverr && prdata == 32'h0000_0000;
   endproperty
   property p_data_quiet;
      @(posedge sys_clk) disable iff (!rst_n) !pready |-> prdata == 32'h0000_0000;
   endproperty
   // Boot outputs stay at the fast defaults until the load, then hold
   property p_fast_first;
      @(posedge sys_clk) disable iff (!rst_n)
         !config_loaded |-> !clk_slow_select && !host_bus_width_select;
   endproperty
   property p_load_once;
      @(posedge sys_clk) disable iff (!rst_n)
         config_loaded && $stable(config_loaded) |=>
            config_loaded && $stable(clk_slow_select) && $stable(host_bus_width_select);
   endproperty
   // Serial framing on the link clock
   property p_sk_in_frame;
      @(posedge link_clk) disable iff (!rst_n) !rom_cs |-> !rom_sk;
   endproperty
   property p_sk_high;
      @(posedge link_clk) disable iff (!rst_n) $rose(rom_sk) |-> rom_sk [*8] ##1 !rom_sk;
   endproperty
   property p_di_hold;
      @(posedge link_clk) disable iff (!rst_n) rom_sk ##1 rom_sk |-> $stable(rom_di);
   endproperty
   property p_cs_lead;
      @(posedge link_clk) disable iff (!rst_n) $rose(rom_cs) |-> !rom_sk [*8];
   endproperty
   property p_cs_gap;
      @(posedge link_clk) disable iff (!rst_n) $fell(rom_cs) |-> !rom_cs [*8];
   endproperty

   a_ready_next: assert property (p_ready_next)
      else $error("no ready after setup");
   a_err_hole: assert property (p_err_hole)
      else $error("unmapped not refused");
   a_data_quiet: assert property (p_data_quiet)
      else $error("read data outside access");
   a_fast_first: assert property (p_fast_first)
      else $error("slow before load");
   a_load_once: assert property (p_load_once)
      else $error("boot outputs moved");
   a_sk_in_frame: assert property (p_sk_in_frame)
      else $error("clock outside frame");
   a_sk_high: assert property (p_sk_high)
      else $error("serial clock high time");
   a_di_hold: assert property (p_di_hold)
      else $error("data moved with clock high");
   a_cs_lead: assert property (p_cs_lead)
      else $error("no lead bit time");
   a_cs_gap: assert property (p_cs_gap)
      else $error("select gap short");

   c_err: cover property (@(posedge sys_clk) pready && pslverr);
   c_load: cover property (@(posedge sys_clk) $rose(config_loaded));
   c_frame: cover property (@(posedge link_clk) $rose(rom_cs));
endmodule : eeprom_config_loader_checker

// ---- tb/microwire_rom_model.sv ----
// Purpose: Behavioural microwire serial EEPROM
// Assumes: Data out changes right after each serial clock rise
// Notes:   No self-timed busy after writes; bench waits instead
`timescale 1ns/1ps
module microwire_rom_model (
   input  wire logic rom_cs,  // Chip select, active high
   input  wire logic rom_sk,  // Serial clock
   input  wire logic rom_di,  // Data into the part
   input  wire logic big,     // 1 = 8-bit address part
   output wire logic rom_do   // Data out
);
   logic [15:0] mem [256];
   logic [16:0] q;
   logic [15:0] dat;
   logic [7:0]  adr;
   logic [7:0]  a;
   logic [1:0]  op;
   logic        wen;
   logic        drv;
   logic [6:0]  seen;
   int          n;
   int          aw;
   int          hi_reads;

   // Recognisable contents; the bench overrides a few words
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = {8'(i), 8'(i) ^ 8'hA5};
      {q, dat, adr, a, op, wen, drv, seen} = '0;
      n = 0;
      hi_reads = 0;
   end

   // Released line floats high on the board pull-up
   assign rom_do = drv ? q[16] : 1'b1;

   // Frame decoder: start bit, opcode, address, then data either way
   always @(posedge rom_sk or negedge rom_cs) begin
      aw = big ? 8 : 6;
      if (!rom_cs) begin
         n = 0;
         drv = 1'b0;
      end else if (n == 0) begin
         n = int'(rom_di);
      end else begin
         n++;
         if (n <= 3)
            op = {op[0], rom_di};
         else if (n <= 3 + aw)
            adr = {adr[6:0], rom_di};
         else
            dat = {dat[14:0], rom_di};
         if (n == 3 + aw) begin
            a = big ? adr : {2'b00, adr[5:0]};
            if (op == 2'b00)
               wen = big ? &adr[7:6] : &adr[5:4];
            if (op == 2'b10) begin
               q = {1'b0, mem[a]}; // Dummy zero, then MSB first
               drv = 1'b1;
               if (a < 8'h07)
                  seen[a[2:0]] = 1'b1;
               else
                  hi_reads++;
            end
         end else if (n > 3 + aw && op == 2'b10) begin
            q = {q[15:0], 1'b0};
            drv = n < 3 + aw + 17;
         end
         if (n == 3 + aw + 16 && op == 2'b01 && wen)
            mem[a] = dat;
      end
   end
endmodule : microwire_rom_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the EEPROM config loader
// Assumes: Small part booted first, then large part with load strapped off
// Notes:   Expected words come from the rom model contents
`timescale 1ns/1ps
`include "eeprom_config_map.svh"
module tb_top;
   logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        link_clk = 0, eeprom_load_enable_pin = 1, big = 0, err;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, clk_slow_select, host_bus_width_select, config_loaded;
   logic        rom_do, rom_cs, rom_sk, rom_di;
   int          fail_count = 0, total_checks = 0;

   // Core clock 4 ns; link clock 64 ns with an odd phase offset
   always #2 sys_clk = ~sys_clk;
   initial begin
      #7.3;
      forever #32 link_clk = ~link_clk;
   end

   eeprom_config_loader u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .eeprom_load_enable_pin, .clk_slow_select,
      .host_bus_width_select, .config_loaded, .link_clk, .rom_do, .rom_cs, .rom_sk, .rom_di);
   microwire_rom_model u_rom (.rom_cs, .rom_sk, .rom_di, .big, .rom_do);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One APB transfer; request held until pready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask : rdchk

   // Poll a control bit; bounded so a stuck busy cannot hang the run
   task automatic wait_ctrl(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, `REG_CTRL, 32'h0000_0000);
         n++;
      end while (rd[b] !== v && n < 9000);
      if (n >= 9000)
         fail_count++;
   endtask : wait_ctrl

   task automatic cmd(input logic [1:0] op, input logic [7:0] a);
      apb(1'b1, `REG_CTRL, {1'b1, 21'h0, op, a});
      wait_ctrl(`CTRL_BUSY_BIT, 1'b0);
   endtask : cmd

   // Held three link periods so the link side sees the reset too
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (48) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // Watchdog; the three tests need about 88k cycles of serial traffic
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end

   // Main sequence
   initial begin
      int n;
      n = 0;
      do_reset();
      // Overrides after time zero, so the model's own fill cannot undo them
      u_rom.mem[6] = 16'hC003; // Slow clock, 16-bit host bus, reserved bits set
      u_rom.mem[8'h80] = 16'h3C69;
      while (config_loaded !== 1'b1 && n < 90000) begin
         @(posedge sys_clk);
         n++;
      end
      check("loaded", 32'(config_loaded), 32'h0000_0001);
      for (int w = 0; w < 4; w++)
         rdchk(`REG_BASE + 8'(4 * w), {16'h0, u_rom.mem[w]}, "boot_word");
      rdchk(`REG_BOOT, 32'h0000_C003, "boot_options_word");
      check("clk_slow", 32'(clk_slow_select), 32'h0000_0001);
      check("bus_width", 32'(host_bus_width_select), 32'h0000_0001);
      apb(1'b0, `REG_CTRL, 32'h0000_0000);
      check("status", 32'(rd[19:16]), 32'h0000_000C);
      check("fetched", 32'(u_rom.seen), 32'h0000_007F);
      check("high_words", 32'(u_rom.hi_reads), 32'h0000_0000);
      apb(1'b1, 8'h40, 32'h0000_FFFF);
      check("unmapped_err", 32'(err), 32'h0000_0001);
      apb(1'b1, `REG_BASE, 32'h0000_FFFF);
      rdchk(`REG_BASE, {16'h0, u_rom.mem[0]}, "base_read_only");
      $display("Test boot_load done");
      cmd(2'b00, 8'h30);
      apb(1'b1, `REG_DATA, 32'h0000_5AC3);
      cmd(`OP_WRITE, 8'h20);
      check("rom_word", 32'(u_rom.mem[8'h20]), 32'h0000_5AC3);
      cmd(`OP_READ, 8'h20);
      rdchk(`REG_DATA, 32'h0000_5AC3, "read_back");
      $display("Test software_access done");
      eeprom_load_enable_pin <= 1'b0; // Boot load strapped off; large part fitted in place of the small one
      big <= 1'b1;
      do_reset();
      check("fast_after_reset", 32'(clk_slow_select), 32'h0000_0000);
      check("narrow_reset", 32'(host_bus_width_select), 32'h0000_0000);
      wait_ctrl(`CTRL_SIZED_BIT, 1'b1);
      check("large_part", 32'(rd[`CTRL_BIG_BIT]), 32'h0000_0001);
      check("no_load", 32'(config_loaded), 32'h0000_0000);
      cmd(`OP_READ, 8'h80);
      rdchk(`REG_DATA, 32'h0000_3C69, "large_read");
      $display("Test large_part done");
      print_verdict();
   end
endmodule : tb_top

bind eeprom_config_loader eeprom_config_loader_checker u_chk (.sys_clk, .rst_n, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .clk_slow_select, .host_bus_width_select,
   .config_loaded, .link_clk, .rom_cs, .rom_sk, .rom_di);
